// *** hw/hfeqr_core.v ***
// High-band envelope copy map, split VQ sequencing, remap, deltas and trim.
`timescale 1ns/100ps
`include "hfeqr_regs.vh"
module hfeqr_core #(
  parameter ENV_W = 16,
  parameter NORM_W = 8,
  parameter BITS_W = 8
) (
  input wire mclk,
  input wire reset_n,
  input wire start,
  input wire high_rate,
  input wire full_band_mode,
  input wire env_wr,
  input wire env_sel,
  input wire [4:0] env_addr,
  input wire [ENV_W-1:0] env_data,
  input wire band_wr,
  input wire [5:0] band_addr,
  input wire [7:0] band_len,
  input wire [NORM_W-1:0] band_norm,
  input wire [BITS_W-1:0] band_bits,
  output reg copy_valid,
  output reg [9:0] copy_src,
  output reg [9:0] copy_dst,
  output reg vq_valid,
  input wire vq_ready,
  output reg [2:0] vq_stage,
  output reg [2:0] vq_elem,
  output reg [ENV_W-1:0] vq_target,
  input wire [ENV_W-1:0] vq_hat,
  input wire [4:0] vq_index,
  output reg idx_valid,
  output reg [4:0] idx_data,
  output reg [23:0] norm_sum,
  output reg delta_valid,
  output reg [5:0] delta_band,
  output reg [5:0] delta_value,
  output reg [NORM_W-1:0] norm_updated,
  output reg [2:0] delta_bit_width,
  output reg [1:0] width_code,
  input wire [5:0] alloc_rd_addr,
  output reg [BITS_W-1:0] alloc_rd_data,
  output wire [15:0] energy_control_gamma,
  output wire busy,
  output reg done,
  output reg refined,
  output reg trim_error
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_COPY = 3'h1;
  localparam [2:0] ST_VQ = 3'h2;
  localparam [2:0] ST_SUM = 3'h3;
  localparam [2:0] ST_MAP = 3'h4;
  localparam [2:0] ST_TRIM = 3'h5;

  reg [2:0] state_reg;
  reg hr_reg;
  reg fb_reg;
  reg [1:0] seg_reg;
  reg [2:0] j_reg;
  reg [5:0] band_reg;
  reg any_high_reg;
  reg [5:0] cnt_reg;
  reg [2:0] maxw_reg;
  reg [8:0] need_reg;
  reg dec_seen_reg;
  reg signed [ENV_W-1:0] f_mem [0:16];
  reg signed [ENV_W-1:0] ehat_mem [0:16];
  reg [7:0] len_mem [0:42];
  reg signed [NORM_W-1:0] norm_mem [0:42];
  reg [BITS_W-1:0] alloc_mem [0:42];

  // Energy control runs upstream; this block supplies its gain.
  assign energy_control_gamma = `HFEQR_GAMMA;
  assign busy = (state_reg != ST_IDLE);

  // Envelope length and band counts follow rate and bandwidth.
  wire [4:0] dims = hr_reg ? `HFEQR_DIMS_HI : `HFEQR_DIMS_LO;
  wire [5:0] lbc = hr_reg ? `HFEQR_LBC_HI : `HFEQR_LBC_LO;
  wire [5:0] nb = fb_reg ? `HFEQR_NB_FB : `HFEQR_NB_SWB;

  function [39:0] copy_seg;
    input hr;
    input [1:0] seg;
    begin
      case ({hr, seg})
        3'h0: copy_seg = {`HFEQR_SRC_A, `HFEQR_SRC_A_END,
                          `HFEQR_LO0_ST, `HFEQR_LO0_END};
        3'h1: copy_seg = {`HFEQR_SRC_A, `HFEQR_SRC_A_END,
                          `HFEQR_LO1_ST, `HFEQR_LO1_END};
        3'h2: copy_seg = {`HFEQR_SRC_B, `HFEQR_SRC_B_END,
                          `HFEQR_LO2_ST, `HFEQR_LO2_END};
        3'h4: copy_seg = {`HFEQR_SRC_A, `HFEQR_SRC_A_END,
                          `HFEQR_HI0_ST, `HFEQR_HI0_END};
        3'h5: copy_seg = {`HFEQR_SRC_A, `HFEQR_SRC_C_END,
                          `HFEQR_HI1_ST, `HFEQR_HI1_END};
        default: copy_seg = 40'h0;
      endcase
    end
  endfunction

  // Returns {first index, second index, first weight, second weight}.
  function [43:0] map_sel;
    input hr;
    input [5:0] band;
    input [4:0] d;
    begin
      if (band >= `HFEQR_FB_FIRST) begin
        // Bands 39..42 carry 3, 0, 1 and 2 in their low two bits.
        case (band[1:0])
          2'h3: map_sel = {d, d, `HFEQR_WONE, 17'h0};
          2'h0: map_sel = {d, d + 5'h01, `HFEQR_W0, `HFEQR_W4};
          2'h1: map_sel = {d + 5'h01, d + 5'h02, `HFEQR_W2, `HFEQR_W2};
          default: map_sel = {d + 5'h02, d + 5'h02, `HFEQR_WONE, 17'h0};
        endcase
      end else begin
        case ({hr, band})
          7'h1b: map_sel = {5'h00, 5'h01, `HFEQR_W1, `HFEQR_W3};
          7'h1c: map_sel = {5'h01, 5'h02, `HFEQR_W1, `HFEQR_W3};
          7'h1d: map_sel = {5'h03, 5'h03, `HFEQR_WONE, 17'h0};
          7'h1e: map_sel = {5'h04, 5'h05, `HFEQR_W3, `HFEQR_W1};
          7'h1f: map_sel = {5'h05, 5'h06, `HFEQR_W3, `HFEQR_W1};
          7'h20: map_sel = {5'h06, 5'h07, `HFEQR_W1, `HFEQR_W3};
          7'h21: map_sel = {5'h07, 5'h08, `HFEQR_W1, `HFEQR_W3};
          7'h22: map_sel = {5'h08, 5'h09, `HFEQR_W1, `HFEQR_W3};
          7'h23: map_sel = {5'h09, 5'h0a, `HFEQR_W1, `HFEQR_W3};
          7'h24: map_sel = {5'h0a, 5'h0b, `HFEQR_W0, `HFEQR_W4};
          7'h25: map_sel = {5'h0c, 5'h0c, `HFEQR_WONE, 17'h0};
          7'h26: map_sel = {5'h0d, 5'h0d, `HFEQR_WONE, 17'h0};
          7'h5e: map_sel = {5'h01, 5'h01, `HFEQR_WONE, 17'h0};
          7'h5f: map_sel = {5'h02, 5'h03, `HFEQR_W3, `HFEQR_W1};
          7'h60: map_sel = {5'h03, 5'h04, `HFEQR_W3, `HFEQR_W1};
          7'h61: map_sel = {5'h04, 5'h05, `HFEQR_W1, `HFEQR_W3};
          7'h62: map_sel = {5'h05, 5'h06, `HFEQR_W1, `HFEQR_W3};
          7'h63: map_sel = {5'h07, 5'h07, `HFEQR_WONE, 17'h0};
          7'h64: map_sel = {5'h08, 5'h09, `HFEQR_W4, `HFEQR_W0};
          7'h65: map_sel = {5'h09, 5'h0a, `HFEQR_W4, `HFEQR_W0};
          7'h66: map_sel = {5'h0a, 5'h0b, `HFEQR_W0, `HFEQR_W4};
          default: map_sel = 44'h0;
        endcase
      end
    end
  endfunction

  // Copy address stream.
  wire [39:0] seg_w = copy_seg(hr_reg, seg_reg);
  wire [1:0] seg_last = hr_reg ? 2'h1 : 2'h2;
  wire copy_seg_end = copy_valid && (copy_dst == seg_w[9:0]);
  wire [39:0] seg_nx = copy_seg(hr_reg, seg_reg + 2'h1);

  // Split VQ sequencing: stage 0 evens plus 11, 1..2 even residual
  // halves, 3..4 odd prediction error halves, 5 full band extras.
  wire [2:0] stg = vq_stage;
  wire vq_take = vq_valid && vq_ready;
  wire vq_last = (stg == 3'h0 && j_reg == 3'h6) ||
    (stg == 3'h1 && j_reg == 3'h2) || (stg == 3'h2 && j_reg == 3'h6) ||
    (stg == 3'h3 && j_reg == 3'h2) || (stg == 3'h4 && j_reg == 3'h5) ||
    (stg == 3'h5 && j_reg == 3'h2);
  wire [4:0] epos = (j_reg == 3'h6) ? 5'h0b : {1'b0, j_reg, 1'b0};
  wire [4:0] opos = (j_reg == 3'h0) ? 5'h01 : {1'b0, j_reg, 1'b0} - 5'h01;
  wire [4:0] opos_lo = (j_reg == 3'h0) ? 5'h00 : opos - 5'h01;
  wire [4:0] opos_hi = (j_reg == 3'h0) ? 5'h00 : opos + 5'h01;
  wire signed [ENV_W:0] pred_sum = ehat_mem[opos_lo] + ehat_mem[opos_hi];
  wire signed [ENV_W-1:0] pred = pred_sum[ENV_W:1];
  wire [4:0] fbpos = dims + {2'h0, j_reg};
  reg signed [ENV_W-1:0] mean_w;
  reg [2:0] ns;
  reg [2:0] nj;
  reg vq_more;
  reg [4:0] tpos;
  reg signed [ENV_W-1:0] tsub;

  always @* begin
    case (j_reg[1:0])
      2'h0: mean_w = `HFEQR_MEAN0;
      2'h1: mean_w = `HFEQR_MEAN1;
      default: mean_w = `HFEQR_MEAN2;
    endcase
    vq_more = 1'b1;
    ns = stg;
    nj = j_reg + 3'h1;
    if (state_reg != ST_VQ) begin
      ns = hr_reg ? 3'h0 : 3'h5;
      nj = 3'h0;
      vq_more = hr_reg || fb_reg;
    end else if (vq_last) begin
      ns = stg + 3'h1;
      nj = (stg == 3'h1 || stg == 3'h3) ? 3'h3 : 3'h0;
      vq_more = (stg < 3'h4) || (stg == 3'h4 && fb_reg);
    end
  end

  // Target of the element presented next, built from stored values.
  wire [4:0] nepos = (nj == 3'h6) ? 5'h0b : {1'b0, nj, 1'b0};
  wire [4:0] nopos = (nj == 3'h0) ? 5'h01 : {1'b0, nj, 1'b0} - 5'h01;
  wire [4:0] nolo = (nj == 3'h0) ? 5'h00 : nopos - 5'h01;
  wire [4:0] nohi = (nj == 3'h0) ? 5'h00 : nopos + 5'h01;
  wire signed [ENV_W:0] npsum = ehat_mem[nolo] + ehat_mem[nohi];
  reg signed [ENV_W-1:0] nmean;
  always @* begin
    case (nj[1:0])
      2'h0: nmean = `HFEQR_MEAN0;
      2'h1: nmean = `HFEQR_MEAN1;
      default: nmean = `HFEQR_MEAN2;
    endcase
    tpos = nepos;
    tsub = {ENV_W{1'b0}};
    case (ns)
      3'h1, 3'h2: tsub = ehat_mem[nepos];
      3'h3, 3'h4: begin
        tpos = nopos;
        tsub = npsum[ENV_W:1];
      end
      3'h5: begin
        tpos = dims + {2'h0, nj};
        tsub = nmean;
      end
      default: tsub = {ENV_W{1'b0}};
    endcase
  end
  wire signed [ENV_W:0] tdiff = f_mem[tpos] - tsub;

  // Remap, delta and updated norm of the band in hand.
  wire [43:0] msel = map_sel(hr_reg, band_reg, dims);
  wire signed [ENV_W+18:0] macc =
    ehat_mem[msel[43:39]] * $signed({1'b0, msel[33:17]}) +
    ehat_mem[msel[38:34]] * $signed({1'b0, msel[16:0]}) +
    $signed(`HFEQR_NORM_RND);
  wire [NORM_W-1:0] norm_map =
    macc[`HFEQR_NORM_SHIFT+NORM_W-1:`HFEQR_NORM_SHIFT];
  wire [NORM_W:0] dlt = {norm_mem[band_reg][NORM_W-1], norm_mem[band_reg]} -
    {norm_map[NORM_W-1], norm_map};
  wire has_bits = (alloc_mem[band_reg] != {BITS_W{1'b0}});
  wire ovp = !dlt[NORM_W] && (dlt[NORM_W-1:5] != {(NORM_W-5){1'b0}});
  wire ovn = dlt[NORM_W] && (dlt[NORM_W-1:5] != {(NORM_W-5){1'b1}});
  wire [5:0] dsat = !has_bits ? 6'h00 : ovp ? `HFEQR_DMAX :
    ovn ? `HFEQR_DMIN : dlt[5:0];
  wire [2:0] wreq = (dsat[5:1] == {5{dsat[5]}}) ? `HFEQR_WMIN :
    (dsat[5:2] == {4{dsat[5]}}) ? 3'h3 :
    (dsat[5:3] == {3{dsat[5]}}) ? 3'h4 : `HFEQR_WMAX;
  wire [2:0] maxw_n = (has_bits && wreq > maxw_reg) ? wreq : maxw_reg;
  wire [5:0] cnt_n = cnt_reg + {5'h00, has_bits};
  wire [8:0] need_n = {3'h0, cnt_n} * {6'h00, maxw_n};

  // Trim and norm sum helpers.
  wire trim_take = (state_reg == ST_TRIM) && (need_reg != 9'h000) &&
    (alloc_mem[band_reg] > `HFEQR_TRIM_FLOOR);
  wire [8:0] need_left = need_reg - {8'h00, trim_take};
  wire sum_use = fb_reg || (band_reg < lbc);
  wire signed [16:0] sum_term = $signed({1'b0, len_mem[band_reg]}) *
    norm_mem[band_reg];
  wire any_high_n = any_high_reg || (band_reg >= lbc && has_bits);

  always @(posedge mclk) begin
    if (env_wr && !env_sel) begin
      f_mem[env_addr] <= env_data;
    end
    if (env_wr && env_sel) begin
      ehat_mem[env_addr] <= env_data;
    end else if (vq_take) begin
      case (stg)
        3'h0: ehat_mem[epos] <= vq_hat;
        3'h1, 3'h2: ehat_mem[epos] <= ehat_mem[epos] + vq_hat;
        3'h3, 3'h4: if (j_reg != 3'h0) begin
          ehat_mem[opos] <= pred + vq_hat;
        end
        default: ehat_mem[fbpos] <= vq_hat + mean_w;
      endcase
    end
    if (band_wr) begin
      len_mem[band_addr] <= band_len;
      norm_mem[band_addr] <= band_norm;
      alloc_mem[band_addr] <= band_bits;
    end else if (trim_take) begin
      alloc_mem[band_reg] <= alloc_mem[band_reg] - 1'b1;
    end
    alloc_rd_data <= alloc_mem[alloc_rd_addr];
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      hr_reg <= 1'b0;
      fb_reg <= 1'b0;
      seg_reg <= 2'h0;
      j_reg <= 3'h0;
      band_reg <= 6'h00;
      any_high_reg <= 1'b0;
      cnt_reg <= 6'h00;
      maxw_reg <= `HFEQR_WMIN;
      need_reg <= 9'h000;
      dec_seen_reg <= 1'b0;
      copy_valid <= 1'b0;
      copy_src <= 10'h000;
      copy_dst <= 10'h000;
      vq_valid <= 1'b0;
      vq_stage <= 3'h0;
      vq_elem <= 3'h0;
      vq_target <= {ENV_W{1'b0}};
      idx_valid <= 1'b0;
      idx_data <= 5'h00;
      norm_sum <= 24'h000000;
      delta_valid <= 1'b0;
      delta_band <= 6'h00;
      delta_value <= 6'h00;
      norm_updated <= {NORM_W{1'b0}};
      delta_bit_width <= `HFEQR_WMIN;
      width_code <= 2'h0;
      done <= 1'b0;
      refined <= 1'b0;
      trim_error <= 1'b0;
    end else begin
      done <= 1'b0;
      idx_valid <= 1'b0;
      delta_valid <= 1'b0;
      case (state_reg)
        ST_IDLE: if (start) begin
          hr_reg <= high_rate;
          fb_reg <= full_band_mode;
          seg_reg <= 2'h0;
          copy_valid <= 1'b1;
          copy_src <= `HFEQR_SRC_A;
          copy_dst <= high_rate ? `HFEQR_HI0_ST : `HFEQR_LO0_ST;
          refined <= 1'b0;
          trim_error <= 1'b0;
          state_reg <= ST_COPY;
        end
        ST_COPY: begin
          copy_dst <= copy_dst + 10'h001;
          copy_src <= (copy_src == seg_w[29:20]) ? seg_w[39:30] :
            copy_src + 10'h001;
          if (copy_seg_end) begin
            seg_reg <= seg_reg + 2'h1;
            copy_src <= seg_nx[39:30];
            copy_dst <= seg_nx[19:10];
            if (seg_reg == seg_last) begin
              copy_valid <= 1'b0;
              vq_valid <= vq_more;
              vq_stage <= ns;
              j_reg <= nj;
              vq_elem <= nj;
              vq_target <= tdiff[ENV_W-1:0];
              state_reg <= vq_more ? ST_VQ : ST_SUM;
              band_reg <= 6'h00;
              norm_sum <= 24'h000000;
              any_high_reg <= 1'b0;
            end
          end
        end
        ST_VQ: if (vq_take) begin
          if (vq_last) begin
            idx_valid <= 1'b1;
            idx_data <= vq_index;
          end
          vq_valid <= vq_more;
          vq_stage <= ns;
          j_reg <= nj;
          vq_elem <= (ns == 3'h2 || ns == 3'h4) ? nj - 3'h3 : nj;
          vq_target <= tdiff[ENV_W-1:0];
          if (!vq_more) begin
            state_reg <= ST_SUM;
          end
        end
        ST_SUM: begin
          if (sum_use) begin
            norm_sum <= norm_sum + {{7{sum_term[16]}}, sum_term};
          end
          any_high_reg <= any_high_n;
          band_reg <= band_reg + 6'h01;
          if (band_reg == nb - 6'h01) begin
            band_reg <= lbc;
            cnt_reg <= 6'h00;
            maxw_reg <= `HFEQR_WMIN;
            state_reg <= any_high_n ? ST_MAP : ST_IDLE;
            done <= !any_high_n;
          end
        end
        ST_MAP: begin
          delta_valid <= 1'b1;
          delta_band <= band_reg;
          delta_value <= dsat;
          norm_updated <= norm_map + {{(NORM_W-6){dsat[5]}}, dsat};
          cnt_reg <= cnt_n;
          maxw_reg <= maxw_n;
          band_reg <= band_reg + 6'h01;
          if (band_reg == nb - 6'h01) begin
            refined <= 1'b1;
            delta_bit_width <= maxw_n;
            width_code <= maxw_n[1:0] - 2'h2;
            need_reg <= need_n;
            dec_seen_reg <= 1'b0;
            band_reg <= nb - 6'h01;
            state_reg <= ST_TRIM;
          end
        end
        ST_TRIM: begin
          need_reg <= need_left;
          dec_seen_reg <= dec_seen_reg || trim_take;
          band_reg <= band_reg - 6'h01;
          if (need_left == 9'h000) begin
            state_reg <= ST_IDLE;
            done <= 1'b1;
          end else if (band_reg == 6'h00) begin
            band_reg <= nb - 6'h01;
            dec_seen_reg <= 1'b0;
            if (!dec_seen_reg && !trim_take) begin
              trim_error <= 1'b1;
              state_reg <= ST_IDLE;
              done <= 1'b1;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// *** pkg/hfeqr_regs.vh ***
// Constants for the high-band envelope quantisation and refinement engine.
// Notes on behaviour
// - Super-wide envelope: 14 dims low, 12 high.
// - Full band adds four bands, same start.
// - Energy control gamma is 0.55 on super-wide bands.
// - Low rate copies 2..129 twice, 80..143 once.
// - High rate copies 2..129, then 2..120.
// - High rate stage one: evens plus 11.
// - Even residuals split three plus four, concatenated.
// - Odd values predicted from reconstructed even neighbours.
// - Odd errors split in two three-element halves.
// - Full band extras minus fixed means, one index.
// - Indices leave in stage order, extra last.
// - Five displacement weights as printed.
// - Low rate maps to bands 27..38.
// - High rate maps to bands 30..38.
// - Full band adds bands 39..42 from last three.
// - Norm sum over low bands, all in full band.
// - Refine only when some high band has bits.
// - Delta is original minus mapped norm, else zero.
// - Delta width 2..5, sent as width minus two.
// - Deltas saturate to 31 and -32.
// - Updated norm is mapped norm plus delta.
// - Trim one bit from bands above three, top down.
// - Low band count is 27 low, 30 high.
`ifndef HFEQR_REGS_VH
`define HFEQR_REGS_VH
`define HFEQR_DIMS_LO 5'h0e
`define HFEQR_DIMS_HI 5'h0c
`define HFEQR_LBC_LO 6'h1b
`define HFEQR_LBC_HI 6'h1e
`define HFEQR_NB_SWB 6'h27
`define HFEQR_NB_FB 6'h2b
`define HFEQR_FB_FIRST 6'h27
`define HFEQR_GAMMA 16'h8ccd
`define HFEQR_W0 17'h04000
`define HFEQR_W1 17'h05600
`define HFEQR_W2 17'h08000
`define HFEQR_W3 17'h0aa00
`define HFEQR_W4 17'h0c000
`define HFEQR_WONE 17'h10000
`define HFEQR_MEAN0 16'h0dc0
`define HFEQR_MEAN1 16'h064a
`define HFEQR_MEAN2 16'h03b3
`define HFEQR_NORM_RND 35'h000800000
`define HFEQR_NORM_SHIFT 24
`define HFEQR_DMAX 6'h1f
`define HFEQR_DMIN 6'h20
`define HFEQR_TRIM_FLOOR 8'h03
`define HFEQR_WMIN 3'h2
`define HFEQR_WMAX 3'h5
`define HFEQR_SRC_A 10'h002
`define HFEQR_SRC_A_END 10'h0ef
`define HFEQR_SRC_B 10'h050
`define HFEQR_SRC_B_END 10'h08f
`define HFEQR_SRC_C_END 10'h0e6
`define HFEQR_LO0_ST 10'h140
`define HFEQR_LO0_END 10'h1bf
`define HFEQR_LO1_ST 10'h1c0
`define HFEQR_LO1_END 10'h23f
`define HFEQR_LO2_ST 10'h240
`define HFEQR_LO2_END 10'h27f
`define HFEQR_HI0_ST 10'h180
`define HFEQR_HI0_END 10'h1ff
`define HFEQR_HI1_ST 10'h200
`define HFEQR_HI1_END 10'h276
`endif

// *** testbench/hfeqr_core_asserts.sv ***
// Concurrent checks on the envelope engine's streams and frame flags.
`timescale 1ns/100ps
module hfeqr_core_asserts (
  input wire mclk,
  input wire reset_n,
  input wire high_rate,
  input wire copy_valid,
  input wire [9:0] copy_src,
  input wire [9:0] copy_dst,
  input wire vq_valid,
  input wire vq_ready,
  input wire [2:0] vq_stage,
  input wire [2:0] vq_elem,
  input wire idx_valid,
  input wire delta_valid,
  input wire [5:0] delta_band,
  input wire [2:0] delta_bit_width,
  input wire [1:0] width_code,
  input wire [15:0] energy_control_gamma,
  input wire done,
  input wire refined,
  input wire trim_error
);
  wire [2:0] last_elem;
  assign last_elem = (vq_stage == 3'h0) ? 3'h6 :
    (vq_stage == 3'h2) ? 3'h3 : 3'h2;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  sequence seq_last_take;
    vq_valid && vq_ready && vq_elem == last_elem;
  endsequence
  sequence seq_index_out;
    idx_valid ##1 !idx_valid;
  endsequence
  chk_index_after_stage: assert property (
    seq_last_take |=> seq_index_out) else $error("stage index pulse missing");
  chk_copy_first: assert property (
    $rose(copy_valid) |-> copy_src == 10'h002 &&
    copy_dst == (high_rate ? 10'h180 : 10'h140)) else $error("bad copy start");
  chk_copy_step: assert property (
    copy_valid && $past(copy_valid) |-> copy_dst == $past(copy_dst) + 10'h001)
    else $error("copy destination skipped");
  chk_copy_seam: assert property (
    copy_valid && copy_dst == (high_rate ? 10'h200 : 10'h1c0) |->
    copy_src == 10'h002) else $error("copy segment source wrong");
  chk_copy_end: assert property (
    $fell(copy_valid) |-> $past(copy_dst) == (high_rate ? 10'h276 : 10'h27f))
    else $error("copy stream ended at wrong bin");
  chk_delta_step: assert property (
    delta_valid && $past(delta_valid) |-> delta_band == $past(delta_band) +
    6'h01) else $error("delta band order broken");
  chk_width_code: assert property (
    done && refined |-> delta_bit_width >= 3'h2 && delta_bit_width <= 3'h5 &&
    width_code == 2'(delta_bit_width - 3'h2)) else $error("bad width code");
  chk_gamma_const: assert property (
    energy_control_gamma == 16'h8ccd) else $error("gamma constant wrong");
  chk_trim_flag: assert property (
    $rose(trim_error) |-> ##[0:2] done) else $error("trim error without done");
endmodule

// *** testbench/hfeqr_vq_partner.sv ***
// Codebook search stand-in on the far side of the offer handshake.
`timescale 1ns/100ps
module hfeqr_vq_partner (
  input wire mclk,
  input wire reset_n,
  input wire stall_en,
  input wire vq_valid,
  input wire [2:0] vq_stage,
  input wire [2:0] vq_elem,
  output logic vq_ready,
  output logic [15:0] vq_hat,
  output logic [4:0] vq_index
);
  logic [15:0] hat_m [0:5][0:6];
  logic [4:0] idx_q [$];
  initial begin
    vq_ready = 1'b0;
    vq_hat = 16'h0000;
    vq_index = 5'h00;
  end
  always @(posedge mclk) begin
    if (reset_n && vq_valid && vq_ready) begin
      hat_m[vq_stage][vq_elem] = vq_hat;
      if (vq_elem == ((vq_stage == 3'h0) ? 3'h6 :
          (vq_stage == 3'h2) ? 3'h3 : 3'h2))
        idx_q.push_back(vq_index);
    end
  end
  // Answers move just after the edge; with no offer the lines keep toggling.
  always @(posedge mclk) begin
    #1;
    vq_ready = stall_en ? 1'($urandom_range(0, 1)) : 1'b1;
    if (vq_valid) begin
      vq_hat = 16'($urandom_range(0, 16'h1fff));
      vq_index = 5'($urandom_range(0, 31));
    end else begin
      vq_hat = ~vq_hat;
      vq_index = ~vq_index;
    end
  end
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the high-band envelope engine.
`timescale 1ns/100ps
module tb_top;
  localparam int KN = 5;
  logic mclk = 1'b0, reset_n = 1'b0, start = 1'b0, stall_en = 1'b0;
  logic high_rate = 1'b0, full_band_mode = 1'b0, env_wr = 1'b0;
  logic env_sel = 1'b0, band_wr = 1'b0;
  logic [4:0] env_addr = 5'h00;
  logic [15:0] env_data = 16'h0000;
  logic [5:0] band_addr = 6'h00, alloc_rd_addr = 6'h00;
  logic [7:0] band_len = 8'h00, band_norm = 8'h00, band_bits = 8'h00;
  logic vq_ready, vq_valid, copy_valid, idx_valid, delta_valid;
  logic busy, done, refined, trim_error;
  logic [4:0] vq_index, idx_data;
  logic [15:0] vq_hat, vq_target, energy_control_gamma;
  logic [5:0] delta_band, delta_value;
  logic [7:0] norm_updated, alloc_rd_data;
  logic [9:0] copy_src, copy_dst;
  logic [2:0] vq_stage, vq_elem, delta_bit_width;
  logic [1:0] width_code;
  logic [23:0] norm_sum;
  logic [15:0] f_m [0:16];
  logic [15:0] mean_m [0:2] = '{16'h0dc0, 16'h064a, 16'h03b3};
  int n_mismatch = 0, cmp_count = 0, n_copy, n_idx, exp_band, dims;
  int len_m [0:42], norm_m [0:42], alloc_m [0:42], d_m [0:42];

  hfeqr_core dut_u (
    .mclk(mclk), .reset_n(reset_n), .start(start), .high_rate(high_rate),
    .full_band_mode(full_band_mode), .env_wr(env_wr), .env_sel(env_sel),
    .env_addr(env_addr), .env_data(env_data), .band_wr(band_wr),
    .band_addr(band_addr), .band_len(band_len), .band_norm(band_norm),
    .band_bits(band_bits), .copy_valid(copy_valid), .copy_src(copy_src),
    .copy_dst(copy_dst), .vq_valid(vq_valid), .vq_ready(vq_ready),
    .vq_stage(vq_stage), .vq_elem(vq_elem), .vq_target(vq_target),
    .vq_hat(vq_hat), .vq_index(vq_index), .idx_valid(idx_valid),
    .idx_data(idx_data), .norm_sum(norm_sum), .delta_valid(delta_valid),
    .delta_band(delta_band), .delta_value(delta_value),
    .norm_updated(norm_updated), .delta_bit_width(delta_bit_width),
    .width_code(width_code), .alloc_rd_addr(alloc_rd_addr),
    .alloc_rd_data(alloc_rd_data),
    .energy_control_gamma(energy_control_gamma), .busy(busy), .done(done),
    .refined(refined), .trim_error(trim_error));
  hfeqr_vq_partner vq_u (
    .mclk(mclk), .reset_n(reset_n), .stall_en(stall_en), .vq_valid(vq_valid),
    .vq_stage(vq_stage), .vq_elem(vq_elem), .vq_ready(vq_ready),
    .vq_hat(vq_hat), .vq_index(vq_index));

  initial begin
    forever #2 mclk = ~mclk;
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tgt(input logic [15:0] e);
    check_val(32'(vq_target), 32'(e));
  endtask

  // Reconstructed even value k: first-stage hat plus residual hat.
  function automatic logic [15:0] ev(input int k);
    return vq_u.hat_m[0][k] + vq_u.hat_m[k < 3 ? 1 : 2][k < 3 ? k : k - 3];
  endfunction

  function automatic logic [15:0] odd_tgt(input int j);
    int p;
    p = (j == 0) ? ev(0) : (ev(j - 1) + ev(j)) >> 1;
    return f_m[j == 0 ? 1 : 2 * j - 1] - 16'(p);
  endfunction

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic int src_exp(input int k);
    if (k < 128)
      return k + 2;
    if (high_rate || k < 256)
      return k - 126;
    return k - 176;
  endfunction

  always @(posedge mclk) begin
    if (reset_n && copy_valid) begin
      check_val(32'(copy_dst), (high_rate ? 384 : 320) + n_copy);
      check_val(32'(copy_src), src_exp(n_copy));
      n_copy++;
    end
    if (reset_n && delta_valid) begin
      check_val(32'(delta_band), exp_band);
      check_val(32'(delta_value), d_m[exp_band] & 32'h3f);
      check_val(32'(norm_updated),
        (KN + d_m[exp_band]) & 32'hff);
      exp_band++;
    end
    if (reset_n && idx_valid) begin
      n_idx++;
      if (vq_u.idx_q.size() > 0)
        check_val(32'(idx_data), 32'(vq_u.idx_q.pop_front()));
      else
        check_val(32'(idx_data), 32'hffffffff);
    end
    if (reset_n && vq_valid && vq_ready) begin
      case (vq_stage)
        3'h0: tgt(f_m[vq_elem == 3'h6 ? 11 : 2 * vq_elem]);
        3'h1: tgt(f_m[2 * vq_elem] - vq_u.hat_m[0][vq_elem]);
        3'h2: tgt(f_m[vq_elem == 3'h3 ? 11 : 2 * vq_elem + 6] -
          vq_u.hat_m[0][vq_elem + 3]);
        3'h3: tgt(odd_tgt(vq_elem));
        3'h4: tgt(odd_tgt(vq_elem + 3));
        3'h5: tgt(f_m[dims + vq_elem] - mean_m[vq_elem]);
        default: ;
      endcase
    end
  end

  task automatic run_frame(input logic hr, input logic fb, input int mode);
    int b, w, need, sum, lim, cnt, lbc, nb;
    logic err;
    lbc = hr ? 30 : 27;
    nb = fb ? 43 : 39;
    sum = 0;
    cnt = 0;
    @(posedge mclk);
    #1;
    high_rate = hr;
    full_band_mode = fb;
    dims = hr ? 12 : 14;
    for (b = 0; b < 34; b++) begin
      if (b < 17)
        f_m[b] = 16'($urandom_range(0, 16'h1fff));
      env_wr = 1'b1;
      env_sel = b >= 17;
      env_addr = 5'(b % 17);
      env_data = (b < 17) ? f_m[b] : 16'(KN * 256);
      @(posedge mclk);
      #1;
    end
    env_wr = 1'b0;
    for (b = 0; b < 43; b++) begin
      len_m[b] = $urandom_range(1, 32);
      norm_m[b] = $urandom_range(0, 90) - 45;
      alloc_m[b] = (mode == 1 && b >= lbc) ? 0 : $urandom_range(0, 9);
      if (mode == 2)
        alloc_m[b] = (b == lbc) ? 2 : $urandom_range(0, 3);
      if (fb || b < lbc)
        sum += len_m[b] * norm_m[b];
      d_m[b] = norm_m[b] - KN;
      if (b < lbc || b >= nb || alloc_m[b] == 0)
        d_m[b] = 0;
      else
        cnt++;
      d_m[b] = (d_m[b] > 31) ? 31 : (d_m[b] < -32) ? -32 : d_m[b];
      band_wr = 1'b1;
      band_addr = 6'(b);
      band_len = 8'(len_m[b]);
      band_norm = 8'(norm_m[b]);
      band_bits = 8'(alloc_m[b]);
      @(posedge mclk);
      #1;
    end
    w = 2;
    for (b = lbc; b < nb; b++)
      while (w < 5 && (d_m[b] >= (1 << (w - 1)) || d_m[b] < -(1 << (w - 1))))
        w++;
    need = cnt * w;
    err = 1'b0;
    while (need > 0 && !err) begin
      err = 1'b1;
      for (b = nb - 1; b >= 0 && need > 0; b--)
        if (alloc_m[b] > 3) begin
          alloc_m[b]--;
          need--;
          err = 1'b0;
        end
    end
    n_copy = 0;
    n_idx = 0;
    exp_band = lbc;
    band_wr = 1'b0;
    start = 1'b1;
    @(posedge mclk);
    #1;
    start = 1'b0;
    lim = 0;
    while (done !== 1'b1 && lim < 30000) begin
      @(posedge mclk);
      #1;
      lim++;
    end
    if (lim == 30000) begin
      n_mismatch++;
      stop_test();
    end
    check_val(32'(norm_sum), sum & 32'hffffff);
    check_val(32'(refined), 32'(cnt > 0));
    check_val(32'(trim_error), 32'(err));
    check_val(32'(busy), 32'h0);
    check_val(n_copy, hr ? 247 : 320);
    check_val(n_idx, (hr ? 5 : 0) + (fb ? 1 : 0));
    check_val(exp_band, cnt > 0 ? nb : lbc);
    if (cnt > 0)
      check_val(32'(delta_bit_width), w);
    for (b = 0; b < nb; b++) begin
      alloc_rd_addr = 6'(b);
      @(posedge mclk);
      #1;
      check_val(32'(alloc_rd_data), alloc_m[b]);
    end
    $display("frame hr=%0d fb=%0d mode=%0d finished", hr, fb, mode);
  endtask

  initial begin
    void'($urandom(3793));
    repeat (16) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    run_frame(1'b0, 1'b0, 0);
    run_frame(1'b0, 1'b1, 1);
    run_frame(1'b0, 1'b0, 2);
    run_frame(1'b1, 1'b0, 1);
    stall_en = 1'b1;
    run_frame(1'b1, 1'b1, 1);
    stop_test();
  end
endmodule

bind hfeqr_core hfeqr_core_asserts chk_u (
  .mclk(mclk), .reset_n(reset_n), .high_rate(high_rate),
  .copy_valid(copy_valid), .copy_src(copy_src), .copy_dst(copy_dst),
  .vq_valid(vq_valid), .vq_ready(vq_ready), .vq_stage(vq_stage),
  .vq_elem(vq_elem), .idx_valid(idx_valid), .delta_valid(delta_valid),
  .delta_band(delta_band), .delta_bit_width(delta_bit_width),
  .width_code(width_code), .energy_control_gamma(energy_control_gamma),
  .done(done), .refined(refined), .trim_error(trim_error));
